// *** design/admux_top.sv ***
// Shared address/data pin multiplexer with general flag mode.
// Assumes the port controller and flag logic run on clk_i, and that
// software disables the port before setting the flag-mode control bit.
`timescale 1ns/1ps
module admux_top
  import admux_pkg::*;
(
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // System control bits.
  input  wire logic [31:0]     system_control_reg_i,
  input  wire admux_width_type port_transfer_width_i,
  // Parallel port request.
  input  wire admux_port_type  port_req_i,
  // General flag logic.
  input  wire logic [15:0]     general_flag_out_i,
  input  wire logic [15:0]     general_flag_oe_i,
  output logic      [15:0]     general_flag_in_o,
  // Parallel port read data.
  output logic      [15:0]     port_rdata_o,
  // Shared address/data pins.
  input  wire logic [15:0]     shared_addr_data_pins_i,
  output logic      [15:0]     shared_addr_data_pins_o,
  output logic      [15:0]     shared_addr_data_pins_oe_o,
  // Strobes, always driven.
  output logic                 ale_o,
  output logic                 rd_n_o,
  output logic                 wr_n_o
);

  // Maps pins to flags: low byte to high flags and back.
  function automatic logic [15:0] swap_bytes(input logic [15:0] v);
    swap_bytes = {v[7:0], v[15:8]};
  endfunction

  // Pins are driven in every address phase and in write data phases.
  function automatic logic [15:0] port_pin_enable(input admux_port_type r);
    port_pin_enable = (r.ale || (r.drive && !r.rd)) ? 16'hFFFF : 16'h0000;
  endfunction

  // A read data phase is a read request with the latch strobe low.
  function automatic logic read_data_phase(input admux_port_type r);
    read_data_phase = r.rd && !r.ale;
  endfunction

  logic rst_s1_r;
  logic rst_sync_n_r;

  // Reset release through two flip-flops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r     <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_s1_r     <= 1'b1;
      rst_sync_n_r <= rst_s1_r;
    end
  end

  logic [15:0]     map_pins;
  logic            flag_mode_r;
  logic            flag_mode_nxt;
  admux_pin_type   pin_r;
  admux_pin_type   pin_nxt;
  logic            ale_r;
  logic            ale_nxt;
  logic            rd_n_r;
  logic            rd_n_nxt;
  logic            wr_n_r;
  logic            wr_n_nxt;
  logic [15:0]     flag_in_r;
  logic [15:0]     flag_in_nxt;
  logic [15:0]     rdata_r;
  logic [15:0]     rdata_nxt;

  admux_phase_map u_map (
    .addr_i  (port_req_i.addr),
    .wdata_i (port_req_i.wdata),
    .ale_i   (port_req_i.ale),
    .width_i (port_transfer_width_i),
    .pins_o  (map_pins)
  );

  // Pin owner. The control bit is registered once here, so every
  // group below switches on the same edge and the pins never see a
  // mix of port and flag values within one cycle.
  always_comb begin
    flag_mode_nxt = system_control_reg_i[ADMUX_FLAG_BIT];
  end

  // Registers the pin owner; reset hands the pins to the port.
  always_ff @(posedge clk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      flag_mode_r <= ADMUX_RST_FLAG;
    end else begin
      flag_mode_r <= flag_mode_nxt;
    end
  end

  // Pin value and enable. In flag mode flag n leaves on pin n+8 for
  // n below 8 and on pin n-8 otherwise. In port mode only the phase
  // mapper and the port request reach the pins, so a stale flag enable
  // cannot fight the external memory.
  always_comb begin
    pin_nxt = '0;
    case (flag_mode_r)
      1'b1: begin
        pin_nxt.o  = swap_bytes(general_flag_out_i);
        pin_nxt.oe = swap_bytes(general_flag_oe_i);
      end
      1'b0: begin
        pin_nxt.o  = map_pins;
        pin_nxt.oe = port_pin_enable(port_req_i);
      end
      default: begin
        pin_nxt = '0;
      end
    endcase
  end

  // Registers the pin drive; reset releases all sixteen pins.
  always_ff @(posedge clk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Strobes. They follow the port request in port mode and sit at
  // their idle levels in flag mode, so a late port request after the
  // switch cannot open a cycle on the external memory.
  always_comb begin
    ale_nxt  = 1'b0;
    rd_n_nxt = 1'b1;
    wr_n_nxt = 1'b1;
    case (flag_mode_r)
      1'b1: begin
        ale_nxt  = 1'b0;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
      end
      1'b0: begin
        ale_nxt  = port_req_i.ale;
        rd_n_nxt = ~port_req_i.rd;
        wr_n_nxt = ~port_req_i.wr;
      end
      default: begin
        ale_nxt  = 1'b0;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
      end
    endcase
  end

  // Registers the strobes; reset leaves them at their idle levels and
  // they are driven in every state, reset included.
  always_ff @(posedge clk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      ale_r  <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
    end else begin
      ale_r  <= ale_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
    end
  end

  // Pin levels as the flag logic sees them. The sample is zero while
  // the port owns the pins, so flag readers never mistake bus traffic
  // for flag inputs.
  always_comb begin
    flag_in_nxt = 16'h0000;
    case (flag_mode_r)
      1'b1:    flag_in_nxt = swap_bytes(shared_addr_data_pins_i);
      1'b0:    flag_in_nxt = 16'h0000;
      default: flag_in_nxt = 16'h0000;
    endcase
  end

  // Registers the flag input sample.
  always_ff @(posedge clk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      flag_in_r <= 16'h0000;
    end else begin
      flag_in_r <= flag_in_nxt;
    end
  end

  // Read data. The pins are taken at each edge of a read data phase,
  // so the last edge before the read strobe rises wins; the value is
  // then held until the next read, and flag mode never disturbs it.
  always_comb begin
    rdata_nxt = rdata_r;
    case (flag_mode_r)
      1'b1: rdata_nxt = rdata_r;
      1'b0: begin
        if (read_data_phase(port_req_i)) begin
          rdata_nxt = shared_addr_data_pins_i;
        end
      end
      default: rdata_nxt = rdata_r;
    endcase
  end

  // Registers the read data.
  always_ff @(posedge clk_i or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs; strobes are never released to high impedance.
  assign shared_addr_data_pins_o    = pin_r.o;
  assign shared_addr_data_pins_oe_o = pin_r.oe;
  assign ale_o                      = ale_r;
  assign rd_n_o                     = rd_n_r;
  assign wr_n_o                     = wr_n_r;
  assign general_flag_in_o          = flag_in_r;
  assign port_rdata_o               = rdata_r;

endmodule

// *** design/admux_pkg.sv ***
// Package for the shared address/data pin multiplexer.
// Assumes a single core clock domain and no software-visible registers.
// Behaviour
// - Flag mode: pins 0-7 to flags 8-15, swap.
// - 8-bit, strobe high: A23-16 upper, A15-8 lower.
// - 8-bit, strobe low: A7-0 upper, data lower.
// - 16-bit, strobe high: A15-0 on pins.
// - 16-bit, strobe low: D15-0 on pins.
// - Read, write, latch strobes always driven.
package admux_pkg;

  localparam int unsigned ADMUX_PIN_W     = 16;
  localparam int unsigned ADMUX_ADDR_W    = 24;
  localparam int unsigned ADMUX_FLAG_BIT  = 20;
  localparam int unsigned ADMUX_HALF_W    = 8;
  localparam logic        ADMUX_RST_FLAG  = 1'b0;
  localparam logic        ADMUX_RST_WIDTH = 1'b0;

  // Transfer width of the parallel port.
  typedef enum logic {
    ADMUX_W8  = 1'b0,
    ADMUX_W16 = 1'b1
  } admux_width_type;

  // One parallel port cycle request from the port controller.
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        ale;
    logic        rd;
    logic        wr;
    logic        drive;
  } admux_port_type;

  // Pin pair for the shared pins: value and output enable.
  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } admux_pin_type;

endpackage

// *** design/admux_phase_map.sv ***
// Phase mapper: picks the bits that the shared pins carry for one phase.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module admux_phase_map
  import admux_pkg::*;
(
  // Request.
  input  wire logic [23:0]     addr_i,
  input  wire logic [15:0]     wdata_i,
  input  wire logic            ale_i,
  input  wire admux_width_type width_i,
  // Pin value.
  output logic      [15:0]     pins_o
);

  // Selects address or data bytes by width and strobe phase.
  always_comb begin
    pins_o = 16'h0000;
    case (width_i)
      ADMUX_W8: begin
        if (ale_i) begin
          pins_o = {addr_i[23:16], addr_i[15:8]};
        end else begin
          pins_o = {addr_i[7:0], wdata_i[7:0]};
        end
      end
      ADMUX_W16: begin
        if (ale_i) begin
          pins_o = addr_i[15:0];
        end else begin
          pins_o = wdata_i;
        end
      end
      default: pins_o = 16'h0000;
    endcase
  end

endmodule

// *** tb/admux_chk.sv ***
// Checker for the shared pin mux, bound to the top.
// Assumes one clock domain.
`timescale 1ns/1ps
module admux_chk
  import admux_pkg::*;
(
  input wire logic            clk_i, rst_n_i,
  input wire logic [31:0]     system_control_reg_i,
  input wire admux_width_type port_transfer_width_i,
  input wire admux_port_type  port_req_i,
  input wire logic [15:0]     general_flag_out_i, general_flag_oe_i,
  input wire logic [15:0]     shared_addr_data_pins_o,
  input wire logic [15:0]     shared_addr_data_pins_oe_o,
  input wire logic            ale_o, rd_n_o, wr_n_o
);
  wire f = system_control_reg_i[ADMUX_FLAG_BIT];
  wire w = port_transfer_width_i;
  wire g = port_req_i.drive & ~port_req_i.rd;
  wire [15:0] d = shared_addr_data_pins_o;
  wire [15:0] e = shared_addr_data_pins_oe_o;
  admux_port_type q, p_r;
  logic [3:0] up_r;
  assign q = port_req_i;
  // Waits out the internal reset copy and keeps the last request.
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) up_r <= '0;
    else up_r <= {up_r[2:0], 1'b1};
  always_ff @(posedge clk_i) p_r <= q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!up_r[3]);
  sequence pm; !f ##1 !f; endsequence
  AST_HI8: assert property (pm ##0 !w && q.ale |=>
    d == p_r.addr[23:8]) else $error("8-bit address phase");
  AST_LO8: assert property (pm ##0 !w && !q.ale && g |=>
    d == {p_r.addr[7:0], p_r.wdata[7:0]}) else $error("8-bit data");
  AST_HI16: assert property (pm ##0 w && q.ale |=>
    d == p_r.addr[15:0]) else $error("16-bit address phase");
  AST_LO16: assert property (pm ##0 w && !q.ale && g |=>
    d == p_r.wdata) else $error("16-bit data phase");
  AST_STRB: assert property (pm |=>
    {ale_o, rd_n_o, wr_n_o} == {p_r.ale, !p_r.rd, !p_r.wr})
    else $error("port strobes");
  AST_IDLE: assert property (f ##1 f |=>
    !ale_o && rd_n_o && wr_n_o) else $error("strobes not idle");
  AST_FLAG: assert property (f ##1 f |=>
    {d[7:0], d[15:8]} == $past(general_flag_out_i) &&
    {e[7:0], e[15:8]} == $past(general_flag_oe_i)) else $error("flags");
  AST_OEN: assert property (pm |=>
    e == {16{p_r.ale | (p_r.drive & !p_r.rd)}}) else $error("pin enable");
  cover property (pm ##0 !w && q.ale);
  cover property (pm ##0 w && q.rd);
  cover property (f ##1 f);
endmodule

// *** tb/admux_mem_model.sv ***
// External address latch and memory on the shared pins.
// Assumes pins_i is the resolved pin level.
`timescale 1ns/1ps
module admux_mem_model (
  input wire logic        clk_i,
  input wire logic        ale_i,
  input wire logic        rd_n_i,
  input wire logic [15:0] pins_i,
  output logic     [15:0] drv_o
);
  logic [15:0] lat_r = 16'h0000;
  // Latches the address on the strobe; drives the pins only during
  // reads and otherwise leaves them at the pull-up level.
  always @(posedge clk_i) begin
    if (ale_i) lat_r <= pins_i;
  end
  assign drv_o = rd_n_i ? 16'hFFFF : ~lat_r;
endmodule

// *** tb/ad_pin_address_data_flag_mux_tb.sv ***
// Bench for the shared pin mux: writes, a read and flag mode.
// Assumes the checker and memory model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected at %0t: mismatch", $time); end end
module ad_pin_address_data_flag_mux_tb;
  import admux_pkg::*;
  logic clk = 0, rst_n = 0;
  logic [31:0] sc = '0;
  admux_width_type w = ADMUX_W8;
  admux_port_type q = '0;
  logic [15:0] fo = '0, foe = '0, rd, po, oe, pi, md, fi;
  logic ale, rdn, wrn;
  int num_errors = 0, comparisons = 0;
  assign pi = (po & oe) | (md & ~oe);
  admux_top u_admux_top (.clk_i(clk), .rst_n_i(rst_n),
    .system_control_reg_i(sc), .port_transfer_width_i(w), .port_req_i(q),
    .general_flag_out_i(fo), .general_flag_oe_i(foe),
    .general_flag_in_o(fi), .port_rdata_o(rd), .shared_addr_data_pins_i(pi),
    .shared_addr_data_pins_o(po), .shared_addr_data_pins_oe_o(oe),
    .ale_o(ale), .rd_n_o(rdn), .wr_n_o(wrn));
  admux_mem_model u_admux_mem_model (.clk_i(clk), .ale_i(ale),
    .rd_n_i(rdn), .pins_i(pi), .drv_o(md));
  initial forever #2 clk = ~clk;
  // One request cycle: ale, rd, wr, drive.
  task step(input logic [3:0] c);
    q[3:0] = c;
    @(negedge clk);
  endtask
  // Address phase, then write data phase.
  task t_write(input admux_width_type wd, input logic [15:0] ea, ed);
    w = wd;
    step(4'b0000);
    step(4'b1001);
    `CHK({ale, oe, po}, {1'b1, 16'hFFFF, ea})
    step(4'b0011);
    `CHK({ale, wrn, po}, {2'b00, ed})
  endtask
  // Read: pins released, memory returns the inverted address.
  task t_read;
    step(4'b1001);
    step(4'b0100);
    `CHK({rdn, oe}, 17'h0_0000)
    step(4'b0100);
    step(4'b0000);
    `CHK(rd, 16'h3C69)
  endtask
  // Flag mode swaps bytes both ways and ignores port requests.
  task t_flag;
    step(4'b0000);
    sc[ADMUX_FLAG_BIT] = 1'b1;
    fo = 16'h1200;
    foe = 16'hFF0F;
    repeat (2) step(4'b0000);
    repeat (2) step(4'b1111);
    `CHK({po, oe}, 32'h0012_0FFF)
    `CHK(fi, 16'h12F0)
    `CHK({ale, rdn, wrn}, 3'b011)
    sc[ADMUX_FLAG_BIT] = 1'b0;
    repeat (3) step(4'b0000);
    `CHK({oe, fi}, 32'h0000_0000)
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cuts a hang short well after the expected run of a few dozen cycles.
  initial begin
    #2000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    q.addr = 24'h5A_C396;
    q.wdata = 16'hB4E1;
    repeat (2) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    t_write(ADMUX_W8, 16'h5AC3, 16'h96E1);
    t_write(ADMUX_W16, 16'hC396, 16'hB4E1);
    t_read;
    t_flag;
    report_and_stop;
  end
endmodule
bind admux_top admux_chk u_admux_chk (.*);
